// ==== rtl/mcs_pkg.sv ====
// Types of the monitor register bank.
`include "mcs_regs.svh"

package mcs_pkg;

  // ==========================================================
  // Whole state of the register bank
  typedef struct packed {
    logic [7:0]             cfg;
    logic [`MCS_CNT_W-1:0]  cnt;
    logic [6:0]             cond;
    logic [7:0]             status;
    logic [7:0]             istat;
    logic [7:0]             imask;
    logic                   irq;
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            prdata;
  } mcs_state_t;

endpackage

// ==== rtl/mcs_regs.svh ====
// Register indices, field positions, reset values and timing counts of the monitor register bank.
`ifndef MCS_REGS_SVH
`define MCS_REGS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define MCS_IDX_CFG    8'h40
`define MCS_IDX_STAT   8'h41
`define MCS_IDX_IMASK  8'h50
`define MCS_IDX_ISTAT  8'h51

// ==========================================================
// Configuration and status field positions
`define MCS_BIT_RUN    0
`define MCS_BIT_LOCK   1
`define MCS_BIT_RDY    2
`define MCS_BIT_FULL_SPEED_OVERRIDE   3
`define MCS_BIT_PWR    4
`define MCS_BIT_SPIN   5
`define MCS_BIT_TMO    6
`define MCS_BIT_SUP    7
`define MCS_BIT_OOL    7

// ==========================================================
// Reset values and masks
`define MCS_CFG_RESET   8'h00
`define MCS_STAT_RESET  8'h00
`define MCS_IMASK_RESET 8'h00
`define MCS_ISTAT_RESET 8'h00
`define MCS_CFG_LOCKED  8'hd3
`define MCS_DEF_LOW     8'h00
`define MCS_DEF_HIGH    8'hff

// ==========================================================
// Timing
`define MCS_CLK_NS      5
`define MCS_POWERUP_NS  1000
`define MCS_POWERUP_CYC ((`MCS_POWERUP_NS + `MCS_CLK_NS - 1) / `MCS_CLK_NS)
`define MCS_CNT_W       16

`endif

// ==== rtl/mcs_top.sv ====
// Configuration and first status register bank of the hardware monitor, APB slave.
//
// Overview of operation
// R01: Run bit selects programmed or default limits.
// R02: Clearing run leaves programmed limits untouched.
// R03: Lock makes the run bit read-only.
// R04: Firmware programs limits before setting run.
// R05: Lock is write-once, cleared only by reset.
// R06: Ready bit sets after power-up delay.
// R07: Full-speed override, reset zero, never locked.
// R08: Lockable power-calculation flag, no side effect.
// R09: Spin-up bypass drives PWM high instead.
// R10: Lockable bit disables bus timeout.
// R11: Lockable bit selects 5 V or 3.3 V scaling.
// R12: Status bits 0-3 flag voltage limits.
// R13: Status bits 4-6 flag temperature limits.
// R14: Status read clears only subsided flags.
// R15: Status bit 7 ORs second status.
// R16: Writes to locked bits are ignored.
// R17: High is strictly above, low at-or-below.
// R18: Flags evaluated per measurement; set beats clear.
`timescale 1ns/1ps
`include "mcs_regs.svh"

module mcs_top import mcs_pkg::*; #(
  parameter int unsigned POWERUP_CYCLES = `MCS_POWERUP_CYC
) (
  // Clock and reset.
  input  wire logic            pclk,
  input  wire logic            presetn,
  // APB slave.
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  input  wire logic [3:0]      pstrb,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  // Measurement results and limits.
  input  wire logic            meas_done,
  input  wire logic [6:0][7:0] reading,
  input  wire logic [6:0][7:0] prog_low,
  input  wire logic [6:0][7:0] prog_high,
  input  wire logic [7:0]      second_status,
  // Configuration towards monitor, fans and bus.
  output logic                 run_monitoring,
  output logic                 limit_lock,
  output logic                 monitor_ready,
  output logic                 full_speed_override,
  output logic                 power_calc_flag,
  output logic                 spinup_bypass,
  output logic                 bus_timeout_off,
  output logic                 supply_5v_scale,
  // Interrupt.
  output logic                 irq
);

  // ==========================================================
  // Elaboration checks
  if (POWERUP_CYCLES < 1 || POWERUP_CYCLES >= (1 << `MCS_CNT_W)) begin : g_bad_powerup
    $error("POWERUP_CYCLES out of range");
  end

  localparam logic [`MCS_CNT_W-1:0] PU_LAST = `MCS_CNT_W'(POWERUP_CYCLES - 1);

  // ==========================================================
  // State
  mcs_state_t st;
  mcs_state_t nx;

  logic       acc_first;
  logic       acc_done;
  logic       wr_done;
  logic       rd_done;
  logic [7:0] idx;
  logic       hit;
  logic [6:0] cond_now;
  logic [7:0] wd;

  // Bus phase decode; pready is registered so every access waits one cycle.
  assign acc_first = psel & penable & ~st.pready;
  assign acc_done  = psel & penable & st.pready;
  assign wr_done   = acc_done & pwrite & ~st.pslverr;
  assign rd_done   = acc_done & ~pwrite & ~st.pslverr;
  assign idx       = paddr[9:2];
  assign wd        = pwdata[7:0];
  assign hit       = (paddr[11:10] == 2'b00) &&
                     (idx == `MCS_IDX_CFG || idx == `MCS_IDX_STAT ||
                      idx == `MCS_IDX_IMASK || idx == `MCS_IDX_ISTAT);

  // ==========================================================
  // Limit comparison per channel
  for (genvar i = 0; i < 7; i++) begin : g_chan
    logic [7:0] eff_low;
    logic [7:0] eff_high;
    // R01 default limits
    // R02 limits kept
    // With monitoring stopped the comparators fall back to the defaults;
    // the programmed inputs are only read, never written here.
    assign eff_low  = st.cfg[`MCS_BIT_RUN] ? prog_low[i]  : `MCS_DEF_LOW;
    assign eff_high = st.cfg[`MCS_BIT_RUN] ? prog_high[i] : `MCS_DEF_HIGH;
    // R17 compare sense
    assign cond_now[i] = (reading[i] > eff_high) || (reading[i] <= eff_low);
  end

  // ==========================================================
  // Next-state logic
  always_comb begin
    nx = st;

    // R06 ready delay
    if (!st.cfg[`MCS_BIT_RDY]) begin
      if (st.cnt == PU_LAST) begin
        nx.cfg[`MCS_BIT_RDY] = 1'b1;
      end else begin
        nx.cnt = st.cnt + `MCS_CNT_W'(1);
      end
    end

    // Register writes take effect at the completing edge only.
    if (wr_done && pstrb[0]) begin
      unique case (idx)
        `MCS_IDX_CFG: begin
          // R16 locked writes ignored
          // R03 run frozen
          // R05 lock write-once
          // Ready is never writable; the override and bypass stay open.
          // Protected bits come from nx so a ready bit set at this same edge survives the write.
          if (st.cfg[`MCS_BIT_LOCK]) begin
            nx.cfg = (nx.cfg & (`MCS_CFG_LOCKED | 8'h04)) | (wd & ~(`MCS_CFG_LOCKED | 8'h04));
          end else begin
            nx.cfg = (nx.cfg & 8'h04) | (wd & ~8'h04);
          end
        end
        `MCS_IDX_IMASK: begin
          nx.imask = wd;
        end
        `MCS_IDX_ISTAT: begin
          nx.istat = st.istat & ~wd;
        end
        default: begin
        end
      endcase
    end

    // R14 clear subsided
    // Only flags whose last measured condition has gone are cleared.
    if (rd_done && idx == `MCS_IDX_STAT) begin
      nx.status[6:0] = st.status[6:0] & st.cond;
    end

    // R12 voltage flags
    // R13 temperature flags
    // R18 set beats clear
    // The set is applied after the clear, so a coinciding event survives.
    if (meas_done) begin
      nx.cond        = cond_now;
      nx.status[6:0] = nx.status[6:0] | cond_now;
    end

    // R15 second-status summary
    nx.status[`MCS_BIT_OOL] = |second_status;

    // Newly set status bits are events; W1C loses against a new event.
    nx.istat = nx.istat | (nx.status & ~st.status);
    nx.irq   = |(nx.istat & nx.imask);

    // Read data and error are registered during the first access cycle.
    if (acc_first) begin
      nx.pready  = 1'b1;
      nx.pslverr = ~hit;
      unique case (idx)
        `MCS_IDX_CFG:   nx.prdata = {24'h000000, st.cfg};
        `MCS_IDX_STAT:  nx.prdata = {24'h000000, st.status};
        `MCS_IDX_IMASK: nx.prdata = {24'h000000, st.imask};
        `MCS_IDX_ISTAT: nx.prdata = {24'h000000, st.istat};
        default:        nx.prdata = 32'h00000000;
      endcase
      if (!hit) begin
        nx.prdata = 32'h00000000;
      end
    end else begin
      nx.pready  = 1'b0;
      nx.pslverr = 1'b0;
    end
  end

  // ==========================================================
  // State register
  // The lock is released only by reset, which stands in for a power cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st         <= '0;
      st.cfg     <= `MCS_CFG_RESET;
      st.status  <= `MCS_STAT_RESET;
      st.imask   <= `MCS_IMASK_RESET;
      st.istat   <= `MCS_ISTAT_RESET;
    end else begin
      st <= nx;
    end
  end

  // ==========================================================
  // Outputs, all straight from the state register
  assign prdata              = st.prdata;
  assign pready              = st.pready;
  assign pslverr             = st.pslverr;
  assign run_monitoring      = st.cfg[`MCS_BIT_RUN];
  assign limit_lock          = st.cfg[`MCS_BIT_LOCK];
  assign monitor_ready       = st.cfg[`MCS_BIT_RDY];
  // R07 full-speed override
  assign full_speed_override = st.cfg[`MCS_BIT_FULL_SPEED_OVERRIDE];
  // R08 power flag
  assign power_calc_flag     = st.cfg[`MCS_BIT_PWR];
  // R09 spin-up bypass
  assign spinup_bypass       = st.cfg[`MCS_BIT_SPIN];
  // R10 timeout off
  assign bus_timeout_off     = st.cfg[`MCS_BIT_TMO];
  // R11 supply scaling
  assign supply_5v_scale     = st.cfg[`MCS_BIT_SUP];
  assign irq                 = st.irq;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic cfg_wr;
  assign cfg_wr = wr_done && pstrb[0] && idx == `MCS_IDX_CFG;

  property p_run_frozen;
    st.cfg[`MCS_BIT_LOCK] |=> $stable(run_monitoring);
  endproperty
  a_run_frozen: assert property (p_run_frozen) else $error("run bit changed under lock"); // R03

  property p_lock_sticky;
    $rose(limit_lock) |=> limit_lock [*8];
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit released"); // R05

  property p_locked_bits;
    st.cfg[`MCS_BIT_LOCK] && cfg_wr |=>
      $stable(power_calc_flag) && $stable(bus_timeout_off) && $stable(supply_5v_scale);
  endproperty
  a_locked_bits: assert property (p_locked_bits) else $error("locked bit written"); // R16

  property p_full_speed_override_open;
    cfg_wr |=> full_speed_override == $past(pwdata[`MCS_BIT_FULL_SPEED_OVERRIDE]);
  endproperty
  a_full_speed_override_open: assert property (p_full_speed_override_open) else $error("override write lost"); // R07

  property p_ready_time;
    $rose(monitor_ready) |-> $past(st.cnt) == PU_LAST;
  endproperty
  a_ready_time: assert property (p_ready_time) else $error("ready at wrong time"); // R06

  property p_flag_set;
    meas_done && cond_now[0] |=> st.status[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set"); // R18

  property p_persist;
    rd_done && idx == `MCS_IDX_STAT && st.status[1] && st.cond[1] |=> st.status[1];
  endproperty
  a_persist: assert property (p_persist) else $error("persisting flag cleared"); // R14

  property p_subside;
    rd_done && idx == `MCS_IDX_STAT && !st.cond[2] && !meas_done |=> !st.status[2];
  endproperty
  a_subside: assert property (p_subside) else $error("subsided flag kept"); // R14

  property p_ool;
    1'b1 |=> st.status[`MCS_BIT_OOL] == $past(|second_status);
  endproperty
  a_ool: assert property (p_ool) else $error("summary bit wrong"); // R15

  property p_default_low;
    !run_monitoring && meas_done && reading[3] == `MCS_DEF_LOW |=> st.status[3] && st.cond[3];
  endproperty
  a_default_low: assert property (p_default_low) else $error("default low missed"); // R01

  property p_high_strict;
    run_monitoring && meas_done && reading[4] == prog_high[4] && reading[4] > prog_low[4]
      |=> !st.cond[4];
  endproperty
  a_high_strict: assert property (p_high_strict) else $error("equal high flagged"); // R17

  c_lock:  cover property ($rose(limit_lock));
  c_clear: cover property (rd_done && idx == `MCS_IDX_STAT && st.status[0] ##1 !st.status[0]);
  c_irq:   cover property ($rose(irq));
  c_lwr:   cover property (cfg_wr && limit_lock);
  c_dflt:  cover property (!run_monitoring && meas_done);

  // ==========================================================
  // Further checks on the configuration and flag paths
  // A missed lock would leave the limits open to any later writer.

  // A first write of one to the lock bit must take.
  property p_lock_set;
    !st.cfg[`MCS_BIT_LOCK] && cfg_wr && pwdata[`MCS_BIT_LOCK] |=> limit_lock;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock write lost"); // R05

  // Only reset may release the lock.
  property p_lock_hold;
    limit_lock |=> limit_lock;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock dropped"); // R05

  // Ready cannot rise before the power-up count has run out.
  property p_rdy_ro;
    !monitor_ready && st.cnt != PU_LAST |=> !monitor_ready;
  endproperty
  a_rdy_ro: assert property (p_rdy_ro) else $error("ready too early"); // R06

  // The spin-up bypass stays writable under the lock.
  property p_bypass_open;
    cfg_wr |=> spinup_bypass == $past(pwdata[`MCS_BIT_SPIN]);
  endproperty
  a_bypass_open: assert property (p_bypass_open) else $error("bypass write lost"); // R09

  // Unlocked writes land in the power flag.
  property p_pwr_open;
    !limit_lock && cfg_wr |=> power_calc_flag == $past(pwdata[`MCS_BIT_PWR]);
  endproperty
  a_pwr_open: assert property (p_pwr_open) else $error("power flag write lost"); // R08

  // Unlocked writes land in the timeout disable.
  property p_tmo_open;
    !limit_lock && cfg_wr |=> bus_timeout_off == $past(pwdata[`MCS_BIT_TMO]);
  endproperty
  a_tmo_open: assert property (p_tmo_open) else $error("timeout bit write lost"); // R10

  // Unlocked writes land in the supply scaling.
  property p_sup_open;
    !limit_lock && cfg_wr |=> supply_5v_scale == $past(pwdata[`MCS_BIT_SUP]);
  endproperty
  a_sup_open: assert property (p_sup_open) else $error("scaling write lost"); // R11

  // Unlocked writes land in the run bit.
  property p_run_open;
    !limit_lock && cfg_wr |=> run_monitoring == $past(pwdata[`MCS_BIT_RUN]);
  endproperty
  a_run_open: assert property (p_run_open) else $error("run write lost"); // R01

  // With run low only a zero reading can violate the default window.
  property p_run_default;
    !run_monitoring && meas_done |=> st.cond[0] == ($past(reading[0]) == `MCS_DEF_LOW);
  endproperty
  a_run_default: assert property (p_run_default) else $error("default window wrong"); // R01

  // A local temperature violation sets its flag.
  property p_temp_set;
    meas_done && cond_now[5] |=> st.status[5];
  endproperty
  a_temp_set: assert property (p_temp_set) else $error("temperature flag not set"); // R13

  // A supply violation sets its flag.
  property p_volt_set;
    meas_done && cond_now[2] |=> st.status[2];
  endproperty
  a_volt_set: assert property (p_volt_set) else $error("voltage flag not set"); // R12

  // A reading equal to the low limit counts as a violation.
  property p_low_equal;
    run_monitoring && meas_done && reading[1] == prog_low[1] |=> st.cond[1];
  endproperty
  a_low_equal: assert property (p_low_equal) else $error("equal low missed"); // R17

  // A new violation in the cycle of a clearing read survives it.
  property p_set_wins;
    rd_done && idx == `MCS_IDX_STAT && meas_done && cond_now[1] |=> st.status[1];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to read"); // R18

endmodule

// ==== test/mcs_host.sv ====
// Host-side APB master model that runs one transfer per request.
`timescale 1ns/1ps
module mcs_host (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Requests from the bench.
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [11:0] addr,
  input  wire logic [7:0]  wdata,
  output logic             done,
  output logic [31:0]      rdata,
  output logic             err,
  // APB master.
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // ==================
  // Transfer sequencer
  // Request held until pready; released data is inverted so a stale value never looks valid.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {done, psel, penable, pwrite, paddr, pwdata, rdata, err} <= '0;
    end else begin
      done <= 1'b0;
      if (!psel && go) begin
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= addr;
        pwdata <= {24'h000000, wdata};
      end else if (psel && !penable) begin
        penable <= 1'b1;
      end else if (psel && pready) begin
        {psel, penable, done} <= 3'b001;
        rdata  <= prdata;
        err    <= pslverr;
        pwdata <= ~pwdata;
      end
    end
  end
endmodule

// ==== test/testbench.sv ====
// Self-checking bench of the monitor configuration and status register bank.
`timescale 1ns/1ps
module testbench;
  // ==================
  // Signals
  typedef struct packed {
    logic        w;
    logic [11:0] a;
    logic [7:0]  d;
    logic [7:0]  e;
    logic        x;
  } mcs_row_t;
  logic            pclk, presetn, go, wr, done, err, meas_done;
  logic            psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0]     addr, paddr;
  logic [7:0]      wdata, second_status, cfg_out;
  logic [31:0]     rdata, pwdata, prdata;
  logic [6:0][7:0] reading, prog_low, prog_high;
  int              miscompares = 0;
  int              checks_done = 0;
  // Write, read back; the lock rows come last since only a reset undoes them.
  mcs_row_t rows [12] = '{
    {1'b1, 12'h100, 8'hf9, 8'h00, 1'b0}, {1'b0, 12'h100, 8'h00, 8'hfd, 1'b0},
    {1'b1, 12'h100, 8'h00, 8'h00, 1'b0}, {1'b0, 12'h100, 8'h00, 8'h04, 1'b0},
    {1'b1, 12'h104, 8'hff, 8'h00, 1'b0}, {1'b0, 12'h104, 8'h00, 8'h00, 1'b0},
    {1'b0, 12'h200, 8'h00, 8'h00, 1'b1}, {1'b1, 12'h100, 8'h03, 8'h00, 1'b0},
    {1'b1, 12'h100, 8'hf8, 8'h00, 1'b0}, {1'b0, 12'h100, 8'h00, 8'h2f, 1'b0},
    {1'b1, 12'h100, 8'h00, 8'h00, 1'b0}, {1'b0, 12'h100, 8'h00, 8'h07, 1'b0}};

  // Short power-up count keeps the run brief.
  mcs_top #(.POWERUP_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas_done(meas_done), .reading(reading), .prog_low(prog_low),
    .prog_high(prog_high), .second_status(second_status), .run_monitoring(cfg_out[0]),
    .limit_lock(cfg_out[1]), .monitor_ready(cfg_out[2]), .full_speed_override(cfg_out[3]),
    .power_calc_flag(cfg_out[4]), .spinup_bypass(cfg_out[5]), .bus_timeout_off(cfg_out[6]),
    .supply_5v_scale(cfg_out[7]), .irq(irq));
  mcs_host host (.pclk(pclk), .presetn(presetn), .go(go), .wr(wr), .addr(addr), .wdata(wdata),
    .done(done), .rdata(rdata), .err(err), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ==================
  // Tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // The done flag is read at the edge after it rises, so no race with the host.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    go <= 1'b1; wr <= w; addr <= a; wdata <= d;
    @(posedge pclk);
    go <= 1'b0;
    while (done !== 1'b1) @(posedge pclk);
  endtask
  task automatic meas();
    meas_done <= 1'b1;
    @(posedge pclk);
    meas_done <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic rst();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // ==================
  // Stimulus
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // About 130 cycles are needed; 20000 means a hang.
  initial begin
    #100000;
    miscompares++;
    close_out();
  end
  initial begin
    {presetn, go, wr, addr, wdata, meas_done, second_status} = '0;
    reading = {7{8'h40}};
    // Limits set before the run bit.
    prog_low = {7{8'h10}}; prog_high = {7{8'h80}};
    rst();
    foreach (rows[i]) begin
      xfer(rows[i].w, rows[i].a, rows[i].d);
      chk("error", rows[i].x, err);
      if (!rows[i].w) chk("read", rows[i].e, rdata);
      if (!rows[i].w && rows[i].a == 12'h100) chk("config", rows[i].e, cfg_out);
    end
    // Boundary readings against programmed limits, masked then unmasked interrupt.
    second_status <= 8'h10;
    reading <= {8'h40, 8'h0f, 8'h80, 8'h11, 8'h81, 8'h10, 8'h40};
    meas();
    chk("irq", 0, irq);
    xfer(1'b1, 12'h140, 8'h04);
    repeat (3) @(posedge pclk);
    chk("irq", 1, irq);
    xfer(1'b0, 12'h144, 8'h00);
    chk("events", 8'ha6, rdata);
    xfer(1'b1, 12'h144, 8'h04);
    repeat (3) @(posedge pclk);
    chk("irq", 0, irq);
    xfer(1'b0, 12'h104, 8'h00);
    chk("status", 8'ha6, rdata);
    reading <= {7{8'h40}};
    second_status <= 8'h00;
    meas();
    xfer(1'b0, 12'h104, 8'h00);
    chk("status", 8'h26, rdata);
    xfer(1'b0, 12'h104, 8'h00);
    chk("status", 8'h00, rdata);
    // Reset releases the lock; defaults apply with the run bit low.
    rst();
    @(posedge pclk);
    chk("config", 8'h00, cfg_out);
    repeat (8) @(posedge pclk);
    chk("config", 8'h04, cfg_out);
    reading <= {8'h05, 8'h05, 8'h05, 8'h00, 8'h05, 8'h05, 8'h00};
    meas();
    xfer(1'b0, 12'h104, 8'h00);
    chk("status", 8'h09, rdata);
    close_out();
  end
endmodule
